//--- rtl/ppd_cfg.svh
// Constants of the pin power-down hold block
// Functional notes
// - Enabled power-down pin driven high puts the device into power-down.
// - Entering power-down captures and holds all outputs and internal states.
// - Registered and combinational outputs keep their entry values during power-down.
// - Outputs tri-stated at entry stay tri-stated through power-down.
// - During power-down every input, clock and output-enable is ignored.
// - Input and I/O hold latches stay active during power-down.
// - Power-down behaviour exists only when selected; otherwise an ordinary pin.
// - With power-down enabled, the pin's array input is blocked from user logic.
// - The power-down pin's macrocell register and foldback stay usable.
// - Pin high for 5 ns makes the device disregard inputs, enables, clocks.
// - Inputs, enables and clocks accepted again within 2 us of pin falling.
// - Outputs valid again within 2 us of the pin falling.
// - Two power-down pins, each able to serve the power-down function.
`ifndef PPD_CFG_SVH
`define PPD_CFG_SVH

`define PPD_N_MC         32
`define PPD_N_SLP        2
`define PPD_SLP1_MC      6
`define PPD_SLP2_MC      30
`define PPD_RST_BIT      1'b0
`define PPD_AWAKE_RST    1'b1

`define PPD_CLK_PERIOD_NS 50
`define PPD_T_SETUP_NS    10
`define PPD_T_IGNORE_NS   5
`define PPD_T_RECOVER_NS  2000

// Least time rounds up, longest time rounds down, never below one cycle
`define PPD_SETUP_CYC   ((`PPD_T_SETUP_NS + `PPD_CLK_PERIOD_NS - 1) / `PPD_CLK_PERIOD_NS)
`define PPD_IGNORE_CYC  ((`PPD_T_IGNORE_NS / `PPD_CLK_PERIOD_NS) < 1 ? 1 : (`PPD_T_IGNORE_NS / `PPD_CLK_PERIOD_NS))
`define PPD_RECOVER_CYC ((`PPD_T_RECOVER_NS / `PPD_CLK_PERIOD_NS) < 1 ? 1 : (`PPD_T_RECOVER_NS / `PPD_CLK_PERIOD_NS))

`endif

//--- rtl/ppd_pkg.sv
// Types of the pin power-down hold block
`include "ppd_cfg.svh"
package ppd_pkg;

   typedef enum logic [1:0] {
      PPD_RUN,
      PPD_DOWN,
      PPD_WAKE
   } ppd_state_e;

   typedef struct packed {
      logic [`PPD_N_MC-1:0] out;
      logic [`PPD_N_MC-1:0] oe;
   } ppd_pins_s;

endpackage

//--- rtl/ppd_hold_bank.sv
// Register bank that holds its contents while frozen
`timescale 1ns/100ps
`include "ppd_cfg.svh"
module ppd_hold_bank #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         hold_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         q_o <= {W{`PPD_RST_BIT}};
      end
      else if (!hold_i)
      begin
         q_o <= d_i;
      end
   end

endmodule

//--- rtl/ppd_recover_timer.sv
// Recovery counter started when the power-down pin falls
`timescale 1ns/100ps
module ppd_recover_timer #(
   parameter int CNT_W = 6,
   parameter int COUNT = 39
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic clr_i,
   input  wire logic run_i,
   output logic      done_o
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] last_w;

   assign last_w = CNT_W'(COUNT - 1);
   assign done_o = run_i && (cnt_q == last_w);

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i || clr_i)
      begin
         cnt_q <= '0;
      end
      else if (run_i && !done_o)
      begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

endmodule

//--- rtl/ppd_top.sv
// Pin power-down hold logic around a bank of macrocells
`timescale 1ns/100ps
`include "ppd_cfg.svh"
module ppd_top
   import ppd_pkg::*;
#(
   parameter int RECOVER_CYC = `PPD_RECOVER_CYC
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   input  wire logic [`PPD_N_SLP-1:0] cfg_slp_en_i,
   input  wire logic [`PPD_N_MC-1:0]  cfg_comb_i,
   input  wire logic                  global_clock_pin_i,
   input  wire logic                  oe_pin_i,
   input  wire logic [`PPD_N_MC-1:0]  io_in_i,
   output logic      [`PPD_N_MC-1:0]  io_out_o,
   output logic      [`PPD_N_MC-1:0]  io_oe_o,
   output logic      [`PPD_N_MC-1:0]  keep_val_o,
   output logic      [`PPD_N_MC-1:0]  keep_en_o,
   output logic                       frozen_o,
   output logic                       awake_o
);

   localparam int N        = `PPD_N_MC;
   localparam int REC_MAX  = `PPD_RECOVER_CYC;
   localparam int IGN_MAX  = `PPD_IGNORE_CYC;
   localparam int TMR_W    = $clog2(RECOVER_CYC + 1);

   // Pin positions of the power-down pins inside the I/O bank
   function automatic logic [N-1:0] slp_mask_f(input logic [`PPD_N_SLP-1:0] en);
      logic [N-1:0] m;
      m                = '0;
      m[`PPD_SLP1_MC]  = en[0];
      m[`PPD_SLP2_MC]  = en[1];
      return m;
   endfunction

   ppd_state_e       state_q;
   ppd_state_e       state_d;
   logic [`PPD_N_SLP-1:0] power_down_pin;
   logic             slp_req;
   logic             freeze;
   logic             tmr_clr;
   logic             tmr_run;
   logic             tmr_done;
   logic [N-1:0]     slp_mask;
   logic [N-1:0]     arr_in;
   logic [N-1:0]     fold;
   logic [N-1:0]     comb_v;
   logic [N-1:0]     mc_q;
   logic [N-1:0]     mc_d;
   logic [N-1:0]     mc_next;
   logic             clk_pin_q;
   logic             clk_edge;
   ppd_pins_s        pins_d;
   ppd_pins_s        pins_q;
   logic [N-1:0]     keep_val_q;
   logic [N-1:0]     keep_en_q;
   logic             frozen_q;
   logic             awake_q;

   // Power-down pins are shared with two macrocell I/O pins
   assign power_down_pin[0] = io_in_i[`PPD_SLP1_MC];
   assign power_down_pin[1] = io_in_i[`PPD_SLP2_MC];

   // A pin acts as power-down only when its option is selected
   assign slp_req  = |(power_down_pin & cfg_slp_en_i);

   // Freeze from the first edge that sees the pin high, until recovery ends
   assign freeze   = slp_req || (state_q != PPD_RUN);

   assign slp_mask = slp_mask_f(cfg_slp_en_i);

   // Array input from an enabled power-down pin is forced low
   assign arr_in   = io_in_i & ~slp_mask;

   // Foldback from the neighbouring macrocell, buried registers included
   assign fold    = {mc_q[0], mc_q[N-1:1]};
   assign comb_v  = arr_in ^ fold;
   assign mc_d    = comb_v;

   // Clock pin edges only count outside the frozen interval
   assign clk_edge = global_clock_pin_i && !clk_pin_q && !freeze;

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         clk_pin_q <= `PPD_RST_BIT;
      end
      else if (!freeze)
      begin
         clk_pin_q <= global_clock_pin_i;
      end
   end

   // Macrocell registers: updated on a clock pin edge, held otherwise
   ppd_hold_bank #(
      .W (N)
   ) u_mc_bank (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .hold_i  (!clk_edge),
      .d_i     (mc_d),
      .q_o     (mc_q)
   );

   assign mc_next    = clk_edge ? mc_d : mc_q;

   // Output pins: registered or combinational per macrocell, with global enable
   assign pins_d.out = (cfg_comb_i & comb_v) | (~cfg_comb_i & mc_next);
   assign pins_d.oe  = {N{oe_pin_i}} & ~slp_mask;

   // Output data and enables, tri-states included, hold while frozen
   ppd_hold_bank #(
      .W ($bits(ppd_pins_s))
   ) u_pin_bank (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .hold_i  (freeze),
      .d_i     (pins_d),
      .q_o     (pins_q)
   );

   // Pin keepers track pin levels while running and hold them while frozen
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         keep_val_q <= '0;
         keep_en_q  <= '0;
      end
      else
      begin
         if (!freeze)
         begin
            keep_val_q <= io_in_i;
         end
         keep_en_q <= {N{freeze}} & ~pins_q.oe;
      end
   end

   // Recovery timer: sequence back to run within the recovery bound
   assign tmr_clr = (state_q != PPD_WAKE);
   assign tmr_run = (state_q == PPD_WAKE) && !slp_req;

   ppd_recover_timer #(
      .CNT_W (TMR_W),
      .COUNT (RECOVER_CYC - 1)
   ) u_timer (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .clr_i   (tmr_clr),
      .run_i   (tmr_run),
      .done_o  (tmr_done)
   );

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         PPD_RUN:
         begin
            if (slp_req)
            begin
               state_d = PPD_DOWN;
            end
         end
         PPD_DOWN:
         begin
            if (!slp_req)
            begin
               state_d = PPD_WAKE;
            end
         end
         PPD_WAKE:
         begin
            if (slp_req)
            begin
               state_d = PPD_DOWN;
            end
            else if (tmr_done)
            begin
               state_d = PPD_RUN;
            end
         end
         default:
         begin
            state_d = PPD_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         state_q     <= PPD_RUN;
         frozen_q    <= `PPD_RST_BIT;
         awake_q     <= `PPD_AWAKE_RST;
      end
      else
      begin
         state_q     <= state_d;
         frozen_q    <= freeze;
         awake_q     <= (state_d == PPD_RUN);
      end
   end

   assign io_out_o    = pins_q.out;
   assign io_oe_o     = pins_q.oe;
   assign keep_val_o  = keep_val_q;
   assign keep_en_o   = keep_en_q;
   assign frozen_o    = frozen_q;
   assign awake_o     = awake_q;

   // Checks of the power-down sequencing
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // Entry is taken on the first edge that sees an enabled pin high
   a_entry_one_edge: assert property (
      (state_q == PPD_RUN) && slp_req |=> (state_q == PPD_DOWN) && frozen_o)
      else $error("power-down not entered on first edge");

   // Inputs ignored within the ignore bound of the pin rising: keepers stop tracking
   a_ignore_bound: assert property (
      $rose(slp_req) |-> ##[1:IGN_MAX] $stable(keep_val_o))
      else $error("inputs not ignored after pin high");

   // Output pins keep their values through the frozen interval
   a_outputs_held: assert property (
      freeze |=> $stable(io_out_o) && $stable(io_oe_o))
      else $error("outputs changed during power-down");

   // Combinational outputs ignore array input changes while frozen
   a_comb_held: assert property (
      freeze && (cfg_comb_i != '0) && !$stable(io_in_i) |=> $stable(io_out_o))
      else $error("combinational output followed input during power-down");

   // With all outputs tri-stated, they stay tri-stated over two frozen cycles
   a_tristate_kept: assert property (
      freeze && (io_oe_o == '0) ##1 freeze |=> (io_oe_o == '0))
      else $error("tri-stated output enabled during power-down");

   // Clock pin edges do not move the macrocell registers while frozen
   a_clock_ignored: assert property (
      freeze && global_clock_pin_i && !$past(global_clock_pin_i) |=> $stable(mc_q))
      else $error("register clocked during power-down");

   // Keepers hold their level on every undriven pin while down
   a_keeper_active: assert property (
      (state_q == PPD_DOWN) && $past(state_q == PPD_DOWN) |->
         ((keep_en_o == ~io_oe_o) && $stable(keep_val_o)))
      else $error("hold latches inactive during power-down");

   // With no pin selected the device never freezes
   a_disabled_plain: assert property (
      (cfg_slp_en_i == '0) && (state_q == PPD_RUN) |=> !frozen_o)
      else $error("power-down taken with option disabled");

   // When enabled, the first power-down pin is not driven as an output outside power-down
   a_sleep_pin_undriven: assert property (
      cfg_slp_en_i[0] && !freeze |=> !io_oe_o[`PPD_SLP1_MC])
      else $error("power-down pin driven as output");

   // Buried register of the shared macrocell still loads its foldback
   a_buried_live: assert property (
      clk_edge && cfg_slp_en_i[1] |=> mc_q[`PPD_SLP2_MC] == $past(fold[`PPD_SLP2_MC]))
      else $error("shared macrocell register not usable");

   // Operation resumes within the recovery bound once the pin is low
   a_wake_bound: assert property (
      (state_q == PPD_DOWN) && !slp_req |-> ##[1:REC_MAX] (awake_o || slp_req))
      else $error("recovery exceeded bound");

   // Register contents at resume equal those of the cycle before
   a_resume_held: assert property (
      (state_q == PPD_WAKE) && (state_d == PPD_RUN) |-> $stable(mc_q))
      else $error("held state lost at resume");

   c_enter_down: cover property ((state_q == PPD_RUN) ##1 (state_q == PPD_DOWN));
   c_wake_done:  cover property ((state_q == PPD_WAKE) ##1 (state_q == PPD_RUN));
   c_second_pin: cover property (power_down_pin[1] && cfg_slp_en_i[1] && !power_down_pin[0]);
   c_rewake:     cover property ((state_q == PPD_WAKE) ##1 (state_q == PPD_DOWN));

endmodule

//--- dv/ppd_board_model.sv
// Board logic model driving the power-down pins, inputs, clock pin and output enable
`timescale 1ns/100ps
`include "ppd_cfg.svh"
module ppd_board_model (
   input  wire logic                 clk_i,
   output logic      [`PPD_N_MC-1:0] io_in_o,
   output logic                      clk_pin_o,
   output logic                      oe_o
);
   initial
   begin
      io_in_o   = 32'h0;
      clk_pin_o = 1'b0;
      oe_o      = 1'b0;
   end

   // Drives always land shortly after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic set(input logic [`PPD_N_MC-1:0] v, input logic oe);
      io_in_o = v;
      oe_o    = oe;
      step(1);
   endtask

   // Inputs settle a full cycle before the pin rises
   task automatic sleep_up(input int pin, input logic [`PPD_N_MC-1:0] v);
      io_in_o = v;
      step(1);
      io_in_o[pin] = 1'b1;
      step(2);
   endtask

   task automatic sleep_down(input int pin);
      io_in_o[pin] = 1'b0;
      step(1);
   endtask

   task automatic clk_pulse();
      clk_pin_o = 1'b1;
      step(2);
      clk_pin_o = 1'b0;
      step(1);
   endtask
endmodule

//--- dv/ppd_top_tb.sv
// Self-checking bench for the pin power-down hold block
`timescale 1ns/100ps
`include "ppd_cfg.svh"
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED %0t %s", $time, m); end end
module ppd_top_tb;
   import ppd_pkg::*;
   localparam int          RC = 4;
   localparam logic [31:0] PM = 32'h4000_0040;
   localparam logic [31:0] VA = 32'h8765_4321;
   logic        clk_i, rst_b_i, clk_pin, oe, frozen, awake;
   logic [1:0]  slp_en;
   logic [31:0] comb, io_in, io_out, io_oe, kv, ke;
   int          miscompares, n_checks;

   ppd_board_model ppd_board_model_i (.clk_i(clk_i), .io_in_o(io_in), .clk_pin_o(clk_pin), .oe_o(oe));
   ppd_top #(.RECOVER_CYC(RC)) ppd_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_slp_en_i(slp_en),
      .cfg_comb_i(comb), .global_clock_pin_i(clk_pin), .oe_pin_i(oe), .io_in_i(io_in), .io_out_o(io_out),
      .io_oe_o(io_oe), .keep_val_o(kv), .keep_en_o(ke), .frozen_o(frozen), .awake_o(awake));

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic end_test(input string s);
      $display("test %s finished", s);
   endtask

   // Lowers the pin and waits for normal operation under a bound
   task automatic wake(input int pin);
      int i;
      i = 0;
      ppd_board_model_i.sleep_down(pin);
      while (awake !== 1'b1 && i < RC + 2)
      begin
         ppd_board_model_i.step(1);
         i++;
      end
      `CHK(i, RC - 1, "recovery time off")
      // The frozen flag reports the edge just passed, so it drops one edge after awake
      ppd_board_model_i.step(1);
      `CHK(frozen, 1'b0, "still frozen")
   endtask

   task automatic t_plain();
      slp_en = 2'b00;
      ppd_board_model_i.set(32'h4f0f_a5c3, 1'b1);
      ppd_board_model_i.step(1);
      `CHK(io_out, 32'h4f0f_a5c3, "unselected pins not ordinary")
      `CHK(frozen, 1'b0, "unselected pins froze")
      `CHK(io_oe, 32'hffff_ffff, "unselected pins not driven")
      slp_en = 2'b10;
      ppd_board_model_i.set(32'h0f0f_a5c3, 1'b1);
      ppd_board_model_i.step(1);
      `CHK(io_out, 32'h0f0f_a5c3, "disabled pin not ordinary")
      `CHK(frozen, 1'b0, "disabled pin froze")
      `CHK(io_oe, 32'hbfff_ffff, "enabled pin still driven")
      end_test("plain");
   endtask

   task automatic t_freeze();
      slp_en = 2'b11;
      ppd_board_model_i.sleep_up(6, 32'h1234_5600);
      `CHK(frozen, 1'b1, "no entry")
      `CHK(awake, 1'b0, "awake while down")
      `CHK(io_out, 32'h1234_5600, "entry value lost")
      ppd_board_model_i.set(32'hedcb_a9ff, 1'b0);
      ppd_board_model_i.clk_pulse();
      comb = 32'h0;
      ppd_board_model_i.step(1);
      `CHK(io_out, 32'h1234_5600, "output moved")
      `CHK(io_oe, ~PM, "enable moved")
      `CHK(kv, 32'h1234_5600, "keeper level moved")
      `CHK(ke, PM, "keeper enable")
      comb = '1;
      ppd_board_model_i.set(32'h2468_ace5, 1'b1);
      wake(6);
      `CHK(io_out, 32'h2468_aca5, "no valid output")
      `CHK(io_oe, ~PM, "no valid enable")
      end_test("freeze");
   endtask

   task automatic t_tristate();
      ppd_board_model_i.set(32'h0, 1'b0);
      ppd_board_model_i.sleep_up(30, 32'h0000_0011);
      ppd_board_model_i.set(32'h4000_0000, 1'b1);
      ppd_board_model_i.step(2);
      `CHK(frozen, 1'b1, "second pin ignored")
      `CHK(io_oe, 32'h0, "high-z left")
      `CHK(ke, 32'hffff_ffff, "keepers off")
      ppd_board_model_i.sleep_down(30);
      ppd_board_model_i.set(32'h4000_0000, 1'b1);
      `CHK(awake, 1'b0, "pin ignored while waking")
      `CHK(io_oe, 32'h0, "high-z left while waking")
      wake(30);
      end_test("tristate");
   endtask

   task automatic t_resume();
      comb = 32'h0;
      ppd_board_model_i.set(VA, 1'b1);
      ppd_board_model_i.clk_pulse();
      `CHK(io_out, VA, "clocked load")
      ppd_board_model_i.sleep_up(6, VA);
      ppd_board_model_i.clk_pulse();
      ppd_board_model_i.set(32'h1357_9b4f, 1'b1);
      wake(6);
      `CHK(io_out, VA, "lost clock acted")
      ppd_board_model_i.clk_pulse();
      `CHK(io_out, 32'h1357_9b0f ^ {VA[0], VA[31:1]}, "resume from held")
      end_test("resume");
   endtask

   initial
   begin
      rst_b_i = 1'b0;
      slp_en  = 2'b00;
      comb    = 32'hffff_ffff;
      repeat (3) @(posedge clk_i);
      #1;
      rst_b_i = 1'b1;
      t_plain();
      t_freeze();
      t_tristate();
      t_resume();
      test_done();
   end

   initial
   begin
      #100000;
      miscompares++;
      test_done();
   end
endmodule
